/* File: rbp_reset_boot_cfg.sv */
// Reset sequencing, strap capture, pin defaults, flow pin and status bit 2
// ---------------------------------------------------------------
// Summary of operation
// ---------------------------------------------------------------
// Summary of operation
// RULE1: Reset aborts activity, fetch address FFFF0h
// RULE2: Reset source holds request low 1 ms
// RULE3: Reset request synchronised to clock internally
// RULE4: Clock stable four periods during reset
// RULE5: First fetch about 6.5 cycles after release
// RULE6: Power-on pin functions and pulls set
// RULE7: Pull option offered per pin group
// RULE8: High-byte strap low restores pins 26, 29
// RULE9: Select one: flow pin is send-request
// RULE10: Select zero: flow pin is receive-ready
// RULE11: Status bit 2 marks memory versus I/O
// RULE12: Status outputs float during hold
// RULE13: Boot width strap: high 16, low 8
// RULE14: Boot width captured once at release
// RULE15: 8-bit boot allows upper region width change
// RULE16: Status code table for bus cycles
// RULE17: All straps sampled on same release edge
`timescale 1ns/1ns
module rbp_reset_boot_cfg
  import rbp_pkg::*;
#(
  parameter int NUM_PIO = RBP_NUM_PIO
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_reset_request_pin_n,
  input wire logic i_boot_width_strap,
  input wire logic i_high_byte_enable_strap,
  input wire logic i_bus_hold,
  input wire logic i_cyc_valid,
  input wire logic i_cyc_mem,
  input wire rbp_cyc_t i_cyc_kind,
  input wire logic i_cyc_inta,
  input wire logic i_flow_ctrl_enable,
  input wire logic i_aux_send_sel,
  input wire logic i_tx_holds_data,
  input wire logic i_rx_holds_unread,
  input wire logic i_upper_width_wr,
  input wire logic i_upper_width_8,
  input wire logic i_pio_cfg_wr,
  input wire logic [NUM_PIO-1:0] i_pio_normal,
  input wire logic [NUM_PIO-1:0] i_pio_pulldn,
  output logic o_cpu_reset,
  output logic o_fetch_start,
  output logic [19:0] o_fetch_addr,
  output logic o_boot_8bit,
  output logic o_upper_mem_select_8bit,
  output logic o_high_byte_enable_strap_low,
  output logic [NUM_PIO-1:0] o_pio_normal,
  output logic [NUM_PIO-1:0] o_pio_pulldn,
  output logic [NUM_PIO-1:0] o_pio_pullup,
  output logic o_flow_pin,
  output logic o_flow_pin_oe_n,
  output logic [2:0] o_cycle_status,
  output logic o_cycle_status_oe_n
);

  // ---------------------------------------------------------------
  // Reset synchronisation
  // ---------------------------------------------------------------
  rbp_sync_if sync();

  rbp_rst_sync u_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_reset_request_pin_n(i_reset_request_pin_n),
    .sync(sync)
  );

  logic rst_any;
  assign rst_any = ~i_rst_n | sync.rst_active; // RULE3

  // ---------------------------------------------------------------
  // Release to first fetch delay
  // ---------------------------------------------------------------
  logic [3:0] fetch_cnt_r;
  logic fetch_busy_r;
  logic fetch_start_r;
  logic [19:0] fetch_addr_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (rst_any)
    begin
      fetch_cnt_r <= 4'h0;
      fetch_busy_r <= 1'b1;
      fetch_start_r <= 1'b0;
    end
    else if (fetch_busy_r)
    begin
      fetch_start_r <= 1'b0;
      if (fetch_cnt_r == 4'(RBP_FETCH_DLY_CYC - 1))
      begin
        fetch_busy_r <= 1'b0;
        fetch_start_r <= 1'b1; // RULE5
      end
      else
        fetch_cnt_r <= fetch_cnt_r + 4'h1;
    end
    else
      fetch_start_r <= 1'b0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (rst_any)
      fetch_addr_r <= RBP_RESET_VECTOR; // RULE1
  end

  assign o_cpu_reset = rst_any | fetch_busy_r; // RULE1
  assign o_fetch_start = fetch_start_r;
  assign o_fetch_addr = fetch_addr_r;

  // ---------------------------------------------------------------
  // Strap capture on synchronised release
  // ---------------------------------------------------------------
  logic boot_8bit_r;
  logic hbe_low_r;
  logic upper_8bit_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      boot_8bit_r <= 1'b0;
      hbe_low_r <= 1'b0;
    end
    else if (sync.release_pulse)
    begin
      boot_8bit_r <= ~i_boot_width_strap; // RULE13 RULE14 RULE17
      hbe_low_r <= ~i_high_byte_enable_strap; // RULE17
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (rst_any)
      upper_8bit_r <= 1'b0;
    else if (sync.release_pulse)
      upper_8bit_r <= ~i_boot_width_strap;
    else if (i_upper_width_wr && boot_8bit_r)
      upper_8bit_r <= i_upper_width_8; // RULE15
  end

  assign o_boot_8bit = boot_8bit_r;
  assign o_upper_mem_select_8bit = upper_8bit_r;
  assign o_high_byte_enable_strap_low = hbe_low_r;

  // ---------------------------------------------------------------
  // Programmable pin configuration
  // ---------------------------------------------------------------
  logic [NUM_PIO-1:0] normal_r;
  logic [NUM_PIO-1:0] pulldn_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (rst_any)
    begin
      normal_r <= NUM_PIO'(RBP_NORMAL_DEFAULT); // RULE6
      pulldn_r <= NUM_PIO'(RBP_PULLDN_DEFAULT); // RULE6
    end
    else if (fetch_busy_r)
    begin
      // Captured strap is only current once the release pulse has passed
      if (hbe_low_r && !sync.release_pulse)
        normal_r <= normal_r | NUM_PIO'(RBP_EMU_PINS); // RULE8
    end
    else if (i_pio_cfg_wr)
    begin
      normal_r <= i_pio_normal;
      // Pulldown only where the pin offers it
      pulldn_r <= i_pio_pulldn
        & NUM_PIO'(RBP_PULLDN_DEFAULT | RBP_PD_OPTION); // RULE7
    end
  end

  assign o_pio_normal = normal_r;
  assign o_pio_pulldn = pulldn_r & ~normal_r;
  assign o_pio_pullup = ~pulldn_r & ~normal_r; // RULE6 RULE7

  // ---------------------------------------------------------------
  // Serial port 0 flow pin
  // ---------------------------------------------------------------
  logic flow_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (rst_any)
      flow_r <= 1'b0;
    else if (i_aux_send_sel)
      flow_r <= i_tx_holds_data; // RULE9
    else
      flow_r <= ~i_rx_holds_unread; // RULE10
  end

  assign o_flow_pin = flow_r;
  assign o_flow_pin_oe_n = ~i_flow_ctrl_enable;

  // ---------------------------------------------------------------
  // Bus cycle status
  // ---------------------------------------------------------------
  function automatic logic [2:0] cyc_code(input logic mem,
                                          input rbp_cyc_t kind,
                                          input logic inta);
    logic [2:0] c;
    c = RBP_ST_PASSIVE;
    case (kind)
      RBP_CYC_READ: c = mem ? RBP_ST_MEMRD : RBP_ST_IORD;
      RBP_CYC_WRITE: c = mem ? RBP_ST_MEMWR : RBP_ST_IOWR;
      RBP_CYC_SPECIAL:
        c = mem ? RBP_ST_FETCH : (inta ? RBP_ST_INTA : RBP_ST_HALT);
      default: c = RBP_ST_PASSIVE;
    endcase
    return c; // RULE16
  endfunction

  logic [2:0] status_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (rst_any || !i_cyc_valid)
      status_r <= RBP_ST_PASSIVE;
    else
      status_r <= cyc_code(i_cyc_mem, i_cyc_kind, i_cyc_inta); // RULE11
  end

  assign o_cycle_status = status_r;
  assign o_cycle_status_oe_n = i_bus_hold; // RULE12

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_release;
    !rst_any ##1 !rst_any;
  endsequence

  a_fetch_delay: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(rst_any) |-> !o_fetch_start [*7] ##1 o_fetch_start) // RULE5
    else $error("fetch start not 7 cycles after release");
  a_reset_vector: assert property (@(posedge i_ref_clk)
    rst_any |=> o_fetch_addr == 20'hF_FFF0 && o_cpu_reset) // RULE1
    else $error("reset vector not loaded");
  a_boot_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !sync.release_pulse |=> $stable(o_boot_8bit)) // RULE14
    else $error("boot width changed outside release");
  a_strap_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sync.release_pulse |=> o_boot_8bit == !$past(i_boot_width_strap)) // RULE13
    else $error("boot width strap not captured");
  a_hbe_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sync.release_pulse |=>
      o_high_byte_enable_strap_low == !$past(i_high_byte_enable_strap)) // RULE17
    else $error("high byte strap not captured");
  a_pio_defaults: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sync.rst_active ##1 sync.rst_active |->
      o_pio_normal[9:4] == 6'h3F && o_pio_pulldn[1] && o_pio_pulldn[10]
      && o_pio_pullup[0]) // RULE6
    else $error("pin defaults wrong in reset");
  a_flow_send: assert property (@(posedge i_ref_clk) disable iff (rst_any)
    s_release ##0 i_aux_send_sel |=> o_flow_pin == $past(i_tx_holds_data)) // RULE9
    else $error("send request level wrong");
  a_flow_recv: assert property (@(posedge i_ref_clk) disable iff (rst_any)
    s_release ##0 !i_aux_send_sel |=> o_flow_pin == !$past(i_rx_holds_unread)) // RULE10
    else $error("receive ready level wrong");
  a_status_mem: assert property (@(posedge i_ref_clk) disable iff (rst_any)
    i_cyc_valid && i_cyc_kind != RBP_CYC_IDLE |=>
      o_cycle_status[2] == $past(i_cyc_mem)) // RULE11
    else $error("status bit 2 does not mark memory");
  a_status_float: assert property (@(posedge i_ref_clk)
    i_bus_hold |-> o_cycle_status_oe_n) // RULE12
    else $error("status driven during hold");
  a_upper_lock: assert property (@(posedge i_ref_clk) disable iff (rst_any)
    !o_boot_8bit && !sync.release_pulse |=> $stable(o_upper_mem_select_8bit)) // RULE15
    else $error("upper width changed in 16-bit boot");

endmodule

/* File: rbp_pkg.sv */
// Package of constants and types for the reset and boot pin configuration block
package rbp_pkg;

  localparam int RBP_NUM_PIO = 32;
  localparam logic [19:0] RBP_RESET_VECTOR = 20'hF_FFF0;
  // Reset request minimum low time (held by the reset source)
  localparam int RBP_REQ_MIN_MS = 1;
  localparam int RBP_CLK_MHZ = 100;
  localparam int RBP_REQ_MIN_CYC = RBP_REQ_MIN_MS * 1000 * RBP_CLK_MHZ;
  // Fetch starts about 6.5 periods after release; rounded up to whole cycles
  localparam int RBP_FETCH_HALF_PERIODS = 13;
  localparam int RBP_FETCH_DLY_CYC = (RBP_FETCH_HALF_PERIODS + 1) / 2;
  localparam int RBP_SYNC_STAGES = 2;

  // Pin function defaults at power-on
  localparam logic [31:0] RBP_NORMAL_DEFAULT = 32'h0000_03F0;
  localparam logic [31:0] RBP_PULLDN_DEFAULT = 32'h0000_0402;
  localparam logic [31:0] RBP_EMU_PINS = 32'h2400_0000;
  // Pins offering pullup or pulldown option when switched to I/O
  localparam logic [31:0] RBP_PU_OPTION = 32'h0000_03B0;
  localparam logic [31:0] RBP_PD_OPTION = 32'h0000_0040;

  // Bus cycle status encodings
  typedef enum logic [2:0] {
    RBP_ST_INTA = 3'h0,
    RBP_ST_IORD = 3'h1,
    RBP_ST_IOWR = 3'h2,
    RBP_ST_HALT = 3'h3,
    RBP_ST_FETCH = 3'h4,
    RBP_ST_MEMRD = 3'h5,
    RBP_ST_MEMWR = 3'h6,
    RBP_ST_PASSIVE = 3'h7
  } rbp_status_t;

  typedef enum logic [1:0] {
    RBP_CYC_IDLE = 2'h0,
    RBP_CYC_READ = 2'h1,
    RBP_CYC_WRITE = 2'h2,
    RBP_CYC_SPECIAL = 2'h3
  } rbp_cyc_t;

endpackage

/* File: rbp_sync_if.sv */
// Interface carrying the reset synchroniser outputs
`timescale 1ns/1ns
interface rbp_sync_if;
  logic rst_active;
  logic release_pulse;
  modport src
  (
    output rst_active,
    output release_pulse
  );
  modport dst
  (
    input rst_active,
    input release_pulse
  );
endinterface

/* File: rbp_rst_sync.sv */
// Reset request synchroniser with release edge detect
`timescale 1ns/1ns
module rbp_rst_sync
  import rbp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_request_pin_n,
  rbp_sync_if.src sync
);

  logic meta_r;
  logic hold_r;
  logic prev_r;

  // Two-stage synchroniser; reset request may arrive at any time
  always_ff @(posedge i_ref_clk)
  begin
    meta_r <= i_reset_request_pin_n;
    hold_r <= meta_r;
  end

  always_ff @(posedge i_ref_clk)
  begin
    prev_r <= hold_r;
  end

  assign sync.rst_active = ~hold_r;
  assign sync.release_pulse = hold_r & ~prev_r;

endmodule

/* File: rbp_partner.sv */
// Model of the external reset source and the board strap resistors
`timescale 1ns/1ns
module rbp_partner
  import rbp_pkg::*;
#(
  parameter int LOW_CYC = RBP_REQ_MIN_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic i_boot_low,
  input wire logic i_hbe_low,
  output logic o_reset_request_pin_n,
  output logic o_boot_width_strap,
  output logic o_high_byte_enable_strap
);
  // Request held low, edges placed off the clock grid
  initial
  begin
    o_reset_request_pin_n = 1'b0;
    forever
    begin
      repeat (LOW_CYC) @(posedge i_ref_clk);
      #3;
      o_reset_request_pin_n = 1'b1;
      @(posedge i_go);
      #7;
      o_reset_request_pin_n = 1'b0;
    end
  end
  // A strap left floating reads high through its pullup
  assign o_boot_width_strap = !i_boot_low;
  assign o_high_byte_enable_strap = !i_hbe_low;
endmodule

/* File: tb.sv */
// Self-checking testbench for the reset and boot pin configuration block
`timescale 1ns/1ns
module tb
  import rbp_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic go = 1'b0, boot_low = 1'b1, hbe_low = 1'b1;
  wire i_reset_request_pin_n, i_boot_width_strap, i_high_byte_enable_strap;
  logic i_bus_hold = 1'b0, i_cyc_valid = 1'b0, i_cyc_mem = 1'b0;
  logic i_cyc_inta = 1'b0, i_flow_ctrl_enable = 1'b0, i_aux_send_sel = 1'b0;
  logic i_tx_holds_data = 1'b0, i_rx_holds_unread = 1'b0;
  logic i_upper_width_wr = 1'b0, i_upper_width_8 = 1'b0, i_pio_cfg_wr = 1'b0;
  rbp_cyc_t i_cyc_kind = RBP_CYC_IDLE;
  logic [31:0] i_pio_normal = 32'h0000_0000, i_pio_pulldn = 32'h0000_0000;
  logic o_cpu_reset, o_fetch_start, o_boot_8bit, o_upper_mem_select_8bit;
  logic o_high_byte_enable_strap_low, o_flow_pin, o_flow_pin_oe_n;
  logic o_cycle_status_oe_n;
  logic [19:0] o_fetch_addr;
  logic [31:0] o_pio_normal, o_pio_pulldn, o_pio_pullup;
  logic [2:0] o_cycle_status;
  int miscompares = 0, checked = 0, cycles = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  // Shortened low time: the block itself does not count it
  rbp_partner #(.LOW_CYC(16)) partner (.i_ref_clk, .i_go(go),
    .i_boot_low(boot_low), .i_hbe_low(hbe_low),
    .o_reset_request_pin_n(i_reset_request_pin_n),
    .o_boot_width_strap(i_boot_width_strap),
    .o_high_byte_enable_strap(i_high_byte_enable_strap));

  rbp_reset_boot_cfg dut (.i_ref_clk, .i_rst_n, .i_reset_request_pin_n,
    .i_boot_width_strap, .i_high_byte_enable_strap, .i_bus_hold, .i_cyc_valid,
    .i_cyc_mem, .i_cyc_kind, .i_cyc_inta, .i_flow_ctrl_enable, .i_aux_send_sel,
    .i_tx_holds_data, .i_rx_holds_unread, .i_upper_width_wr, .i_upper_width_8,
    .i_pio_cfg_wr, .i_pio_normal, .i_pio_pulldn, .o_cpu_reset, .o_fetch_start,
    .o_fetch_addr, .o_boot_8bit, .o_upper_mem_select_8bit,
    .o_high_byte_enable_strap_low, .o_pio_normal, .o_pio_pulldn, .o_pio_pullup,
    .o_flow_pin, .o_flow_pin_oe_n, .o_cycle_status, .o_cycle_status_oe_n);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task step;
    @(negedge i_ref_clk);
  endtask

  task give_verdict;
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_boot(input logic b8, input logic lo);
    int n;
    logic [31:0] nrm;
    n = 0;
    nrm = RBP_NORMAL_DEFAULT | (lo ? RBP_EMU_PINS : 32'h0000_0000);
    chk(o_cpu_reset, 1'b1);
    chk(o_fetch_addr, RBP_RESET_VECTOR);
    chk(o_cycle_status, RBP_ST_PASSIVE);
    @(posedge i_reset_request_pin_n);
    while (o_fetch_start !== 1'b1 && n < 40)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk(n >= 7 && n <= 11, 1'b1);
    chk(o_cpu_reset, 1'b0);
    chk(o_fetch_addr, RBP_RESET_VECTOR);
    chk(o_boot_8bit, b8);
    chk(o_high_byte_enable_strap_low, lo);
    chk(o_pio_normal, nrm);
    chk(o_pio_pulldn, RBP_PULLDN_DEFAULT);
    chk(o_pio_pullup, ~(nrm | RBP_PULLDN_DEFAULT));
    $display("test boot done");
  endtask

  task automatic test_flow;
    step;
    for (int i = 0; i < 8; i++)
    begin
      i_flow_ctrl_enable = 1'b1;
      {i_aux_send_sel, i_tx_holds_data, i_rx_holds_unread} = i[2:0];
      step;
      chk(o_flow_pin, i[2] ? i[1] : !i[0]);
      chk(o_flow_pin_oe_n, 1'b0);
    end
    i_flow_ctrl_enable = 1'b0;
    step;
    chk(o_flow_pin_oe_n, 1'b1);
    $display("test flow done");
  endtask

  task automatic test_status;
    logic [2:0] e;
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 4; k++)
        for (int a = 0; a < 2; a++)
        begin
          i_cyc_valid = 1'b1;
          i_cyc_mem = m[0];
          i_cyc_kind = rbp_cyc_t'(k);
          i_cyc_inta = a[0];
          step;
          case (k)
            0: e = 3'h7;
            1: e = m ? 3'h5 : 3'h1;
            2: e = m ? 3'h6 : 3'h2;
            default: e = m ? 3'h4 : (a ? 3'h0 : 3'h3);
          endcase
          chk(o_cycle_status, e);
          if (k != 0)
            chk(o_cycle_status[2], m[0]);
        end
    i_cyc_valid = 1'b0;
    i_bus_hold = 1'b1;
    step;
    chk(o_cycle_status, RBP_ST_PASSIVE);
    chk(o_cycle_status_oe_n, 1'b1);
    i_bus_hold = 1'b0;
    step;
    chk(o_cycle_status_oe_n, 1'b0);
    $display("test status done");
  endtask

  task automatic test_pio;
    i_pio_normal = 32'h0000_0000;
    i_pio_pulldn = 32'hFFFF_FFFF;
    i_pio_cfg_wr = 1'b1;
    step;
    i_pio_cfg_wr = 1'b0;
    step;
    chk(o_pio_pulldn, RBP_PULLDN_DEFAULT | RBP_PD_OPTION);
    chk(o_pio_pullup & RBP_PU_OPTION, RBP_PU_OPTION);
    $display("test pio done");
  endtask

  task automatic test_lock;
    boot_low = 1'b0;
    hbe_low = 1'b0;
    repeat (3) step;
    chk(o_boot_8bit, 1'b1);
    chk(o_high_byte_enable_strap_low, 1'b1);
    for (int v = 0; v < 2; v++)
    begin
      i_upper_width_8 = v[0];
      i_upper_width_wr = 1'b1;
      step;
      i_upper_width_wr = 1'b0;
      chk(o_upper_mem_select_8bit, v[0]);
      step;
    end
    $display("test lock done");
  endtask

  task automatic test_refuse;
    step;
    i_upper_width_8 = 1'b1;
    i_upper_width_wr = 1'b1;
    step;
    i_upper_width_wr = 1'b0;
    step;
    chk(o_upper_mem_select_8bit, 1'b0);
    $display("test refuse done");
  endtask

  initial
  begin
    repeat (8) step;
    i_rst_n = 1'b1;
    test_boot(1'b1, 1'b1);
    test_flow;
    test_status;
    test_pio;
    test_lock;
    go = 1'b1;
    repeat (5) step;
    go = 1'b0;
    test_boot(1'b0, 1'b0);
    test_refuse;
    give_verdict;
  end
endmodule
